// ---- src/pcs_pkg.sv ----
// Constants for the PC card socket status and power register bank.
// Assumes an APB master with 32-bit data and byte addressing.
package pcs_pkg;
    localparam int PCS_SOCKETS = 4;
    localparam logic [7:0] PCS_SOCK_STRIDE = 8'h40;
    localparam logic [7:0] PCS_IDX_PIN_STATUS = 8'h01;
    localparam logic [7:0] PCS_IDX_POWER_CTRL = 8'h02;
    localparam logic [7:0] PCS_IDX_CHANGE_STATUS = 8'h04;
    localparam logic [7:0] PCS_IDX_CHANGE_ENABLE = 8'h05;
    localparam logic [7:0] PCS_IDX_CARD_DETECT_CTRL = 8'h16;
    localparam logic [7:0] PCS_IDX_GLOBAL_CTRL = 8'h1e;
    localparam logic [7:0] PCS_IDX_CARD_TYPE = 8'h3f;
    localparam logic [7:0] PCS_POWER_RESET = 8'h00;
    localparam logic [7:0] PCS_CHANGE_RESET = 8'h00;
    localparam logic [7:0] PCS_ENABLE_RESET = 8'h00;
    localparam logic [7:0] PCS_GLOBAL_RESET = 8'h00;
    localparam int PCS_ST_POWER = 6;
    localparam int PCS_ST_READY = 5;
    localparam int PCS_ST_WP = 4;
    localparam int PCS_ST_CD2 = 3;
    localparam int PCS_ST_CD1 = 2;
    localparam int PCS_ST_BATTERY_DETECT_TWO = 1;
    localparam int PCS_ST_BATTERY_DETECT_ONE = 0;
    localparam int PCS_PC_OE = 7;
    localparam int PCS_PC_AUTO = 5;
    localparam int PCS_PC_VCC_HI = 4;
    localparam int PCS_PC_VCC_LO = 3;
    localparam int PCS_PC_VPP_HI = 1;
    localparam int PCS_PC_VPP_LO = 0;
    localparam int PCS_CH_DETECT = 3;
    localparam int PCS_CH_READY = 2;
    localparam int PCS_CH_WARN = 1;
    localparam int PCS_CH_DEAD = 0;
    localparam int PCS_GC_ACK_MODE = 2;
    localparam int PCS_CD_SW_INT = 5;
    localparam logic [1:0] PCS_VCC_OFF = 2'h0;
    localparam logic [1:0] PCS_VCC_5V = 2'h2;
    localparam logic [1:0] PCS_VCC_3V = 2'h3;
    localparam logic [1:0] PCS_VPP_5V = 2'h1;
    localparam logic [1:0] PCS_VPP_12V = 2'h2;
    typedef enum logic [2:0] {
        PCS_APB_IDLE = 3'h1,
        PCS_APB_WAIT = 3'h2,
        PCS_APB_DONE = 3'h4
    } pcs_apb_state_t;
endpackage

// ---- src/pcs_socket.sv ----
// One socket: pin sync, status, power switch decode, change flags.
// Assumes pins synchronous to sys_clk_i; register writes arrive as strobes.
module pcs_socket
    import pcs_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [6:0] pins_i,
    input wire logic [1:0] vsense_i,
    input wire logic is_io_i,
    input wire logic ack_mode_i,
    input wire logic [7:0] change_en_i,
    input wire logic power_we_i,
    input wire logic change_we_i,
    input wire logic change_rd_i,
    input wire logic sw_detect_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] status_o,
    output logic [7:0] power_o,
    output logic [7:0] change_o,
    output logic [3:0] switch_o,
    output logic oe_o,
    output logic any_change_o
);
    logic [6:0] sync1_ff;
    logic [6:0] pin_ff;
    logic [6:0] prev_ff;
    logic [7:0] power_ff;
    logic [3:0] change_ff;
    logic [3:0] nxt_change;
    logic [3:0] set_ev;
    logic [1:0] vcc_sel;
    logic [1:0] vpp_sel;
    logic card_in;

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sync1_ff <= '0;
            pin_ff <= '0;
            prev_ff <= '0;
        end else begin
            sync1_ff <= pins_i; // RULE_25
            pin_ff <= sync1_ff;
            prev_ff <= pin_ff;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            power_ff <= PCS_POWER_RESET; // RULE_07
        end else if (power_we_i) begin
            power_ff <= {wdata_i[7], 1'b0, wdata_i[5:3], 1'b0, wdata_i[1:0]};
        end
    end

    // Auto switching picks supply from sampled sense pins when seated
    assign card_in = pin_ff[PCS_ST_CD1] & pin_ff[PCS_ST_CD2];
    always_comb begin
        vcc_sel = power_ff[PCS_PC_VCC_HI:PCS_PC_VCC_LO];
        if (power_ff[PCS_PC_AUTO]) begin // RULE_10
            vcc_sel = !card_in ? PCS_VCC_OFF : (vsense_i[0] ? PCS_VCC_5V : PCS_VCC_3V);
        end
        vpp_sel = 2'h0;
        if (vcc_sel[1]) begin // RULE_12
            case (power_ff[PCS_PC_VPP_HI:PCS_PC_VPP_LO])
                PCS_VPP_5V: vpp_sel = 2'h1;
                PCS_VPP_12V: vpp_sel = 2'h2;
                default: vpp_sel = 2'h0;
            endcase
        end
    end

    always_comb begin
        set_ev[PCS_CH_DETECT] = (pin_ff[3:2] != prev_ff[3:2]) | sw_detect_i; // RULE_19
        set_ev[PCS_CH_READY] = !is_io_i & pin_ff[PCS_ST_READY] & !prev_ff[PCS_ST_READY]; // RULE_20
        set_ev[PCS_CH_WARN] = !is_io_i & (pin_ff[1:0] == 2'h1)
            & (prev_ff[1:0] != 2'h1); // RULE_21
        set_ev[PCS_CH_DEAD] = is_io_i ? (!pin_ff[0] & prev_ff[0])
            : (!pin_ff[0] & prev_ff[0]); // RULE_22
        set_ev = set_ev & change_en_i[3:0];
        nxt_change = change_ff;
        if (change_rd_i && !ack_mode_i) begin
            nxt_change = '0; // RULE_15
        end
        if (change_we_i && ack_mode_i) begin
            nxt_change = nxt_change & ~wdata_i[3:0]; // RULE_14
        end
        nxt_change = (nxt_change | set_ev) & change_en_i[3:0]; // RULE_13
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            change_ff <= PCS_CHANGE_RESET[3:0]; // RULE_18
        end else begin
            change_ff <= nxt_change;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            switch_o <= '0;
            oe_o <= 1'b0;
            any_change_o <= 1'b0;
        end else begin
            switch_o <= {vcc_sel == PCS_VCC_5V, vcc_sel == PCS_VCC_3V, vpp_sel}; // RULE_11
            oe_o <= power_ff[PCS_PC_OE]; // RULE_08
            any_change_o <= |nxt_change; // RULE_16
        end
    end

    assign status_o = {1'b0, vcc_sel[1], pin_ff[5:0]}; // RULE_01
    assign power_o = power_ff;
    assign change_o = {4'h0, change_ff};
endmodule // pcs_socket

// ---- src/pcs_bank.sv ----
// Four-socket status, power and card change register bank with APB slave.
// Assumes card pins synchronous to sys_clk_i; power latch and socket
// buffers sit outside. Software powers the socket before setting output enable.
// Contract
// RULE_01: Status bit 6 reads 1 while socket supply is applied.
// RULE_02: Status bit 5 follows the card ready pin.
// RULE_03: Status bit 4 shows write-protect pin; blocking lives elsewhere.
// RULE_04: Status bits 2 and 3 follow card detect one and two.
// RULE_05: Status bits 1:0 show battery detect pins for memory cards.
// RULE_06: For I/O cards bits 0 and 1 show status-change and speaker pins.
// RULE_07: Reset clears the whole power control register.
// RULE_08: Output enable off tri-states socket outputs and buffer enable.
// RULE_09: Software sets supply before output enable, keeps it off unpowered.
// RULE_10: Auto power switch drives supply from detects and sense pins.
// RULE_11: Supply field 10 selects 5V, 11 selects 3.3V, else none.
// RULE_12: Programming field 01 low enable, 10 high enable, needs bit 4; in auto mode the code gates on the auto-selected supply instead.
// RULE_13: Change bits read 0 while their enable bit is clear.
// RULE_14: In explicit mode writing 1 clears a change bit.
// RULE_15: In read mode any read clears all change bits.
// RULE_16: Further changes while pending give no second interrupt edge.
// RULE_17: Handler reads the change register before leaving.
// RULE_18: Reset clears the whole change register.
// RULE_19: Detect change sets on either detect edge or software request.
// RULE_20: Ready change sets on ready rising edge, memory cards only.
// RULE_21: Battery warning change sets on warning, memory cards only.
// RULE_22: Bit 0 sets on dead battery or status-change pin falling low.
// RULE_23: Global acknowledge-mode bit selects explicit write or read clear.
// RULE_24: Each of four sockets has its own register set; the code keeps one global control register shared by all sockets.
// RULE_25: Card pins are synchronised before use.
module pcs_bank
    import pcs_pkg::*;
#(
    parameter int SOCKETS = PCS_SOCKETS
)(
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [9:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [SOCKETS*7-1:0] card_pins_i,
    input wire logic [SOCKETS*2-1:0] voltage_sense_i,
    output logic [SOCKETS-1:0] supply_high_select_o,
    output logic [SOCKETS-1:0] supply_low_select_o,
    output logic [SOCKETS-1:0] prog_voltage_high_enable_o,
    output logic [SOCKETS-1:0] prog_voltage_low_enable_o,
    output logic [SOCKETS-1:0] socket_out_en_o,
    output logic [SOCKETS-1:0] buffer_enable_n_o,
    output logic [SOCKETS-1:0] change_pending_o
);
    pcs_apb_state_t state_ff;
    logic [7:0] global_ff;
    logic [SOCKETS-1:0] card_type_ff;
    logic [7:0] change_en_ff [SOCKETS];
    logic [1:0] vsense_ff [SOCKETS];
    logic [7:0] status_w [SOCKETS];
    logic [7:0] power_w [SOCKETS];
    logic [7:0] change_w [SOCKETS];
    logic [3:0] switch_w [SOCKETS];
    logic [SOCKETS-1:0] oe_w;
    logic [SOCKETS-1:0] pend_w;
    logic [1:0] sock;
    logic [7:0] idx;
    logic access;
    logic wr;
    logic rd;
    logic hit;
    logic [7:0] rbyte;

    function automatic logic is_reg(input logic [7:0] i);
        return i == PCS_IDX_PIN_STATUS || i == PCS_IDX_POWER_CTRL
            || i == PCS_IDX_CHANGE_STATUS || i == PCS_IDX_CHANGE_ENABLE
            || i == PCS_IDX_CARD_DETECT_CTRL || i == PCS_IDX_GLOBAL_CTRL
            || i == PCS_IDX_CARD_TYPE;
    endfunction

    // Word address = index * 4; address bits 9:8 above the index pick the socket
    assign sock = paddr_i[9:8];
    assign idx = {2'h0, paddr_i[7:2]};
    assign access = psel_i && penable_i && (state_ff == PCS_APB_WAIT);
    assign hit = is_reg(idx) && (paddr_i[1:0] == 2'h0) && (32'(sock) < SOCKETS);
    assign wr = access && pwrite_i && hit && pstrb_i[0];
    assign rd = access && !pwrite_i && hit;

    // One wait state so the read data is registered
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_ff <= PCS_APB_IDLE;
        end else begin
            case (state_ff)
                PCS_APB_IDLE: if (psel_i && !penable_i) state_ff <= PCS_APB_WAIT;
                PCS_APB_WAIT: if (psel_i && penable_i) state_ff <= PCS_APB_DONE;
                PCS_APB_DONE: state_ff <= psel_i && !penable_i ? PCS_APB_WAIT : PCS_APB_IDLE;
                default: state_ff <= PCS_APB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            global_ff <= PCS_GLOBAL_RESET;
            card_type_ff <= '0;
        end else if (wr && idx == PCS_IDX_GLOBAL_CTRL) begin
            global_ff <= {5'h0, pwdata_i[PCS_GC_ACK_MODE], 2'h0}; // RULE_23
        end else if (wr && idx == PCS_IDX_CARD_TYPE) begin
            card_type_ff[sock] <= pwdata_i[0];
        end
    end

    always_comb begin
        rbyte = 8'h00;
        case (idx)
            PCS_IDX_PIN_STATUS: rbyte = status_w[sock]; // RULE_02 RULE_03 RULE_04 RULE_05 RULE_06
            PCS_IDX_POWER_CTRL: rbyte = power_w[sock];
            PCS_IDX_CHANGE_STATUS: rbyte = change_w[sock];
            PCS_IDX_CHANGE_ENABLE: rbyte = change_en_ff[sock];
            PCS_IDX_CARD_DETECT_CTRL: rbyte = {vsense_ff[sock][1], vsense_ff[sock][0], 6'h00};
            PCS_IDX_GLOBAL_CTRL: rbyte = global_ff;
            PCS_IDX_CARD_TYPE: rbyte = {7'h00, card_type_ff[sock]};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= '0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && penable_i && (state_ff == PCS_APB_WAIT);
            pslverr_o <= access && !hit;
            prdata_o <= rd ? {24'h0, rbyte} : 32'h0;
        end
    end

    genvar g;
    generate
        for (g = 0; g < SOCKETS; g++) begin : g_sock // RULE_24
            logic sel;
            assign sel = 32'(sock) == g;
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    change_en_ff[g] <= PCS_ENABLE_RESET;
                    vsense_ff[g] <= '0;
                end else begin
                    vsense_ff[g] <= voltage_sense_i[g*2 +: 2];
                    if (wr && sel && idx == PCS_IDX_CHANGE_ENABLE) begin
                        change_en_ff[g] <= {4'h0, pwdata_i[3:0]};
                    end
                end
            end
            pcs_socket u_sock (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .pins_i(card_pins_i[g*7 +: 7]),
                .vsense_i(vsense_ff[g]),
                .is_io_i(card_type_ff[g]),
                .ack_mode_i(global_ff[PCS_GC_ACK_MODE]),
                .change_en_i(change_en_ff[g]),
                .power_we_i(wr && sel && idx == PCS_IDX_POWER_CTRL),
                .change_we_i(wr && sel && idx == PCS_IDX_CHANGE_STATUS),
                .change_rd_i(rd && sel && idx == PCS_IDX_CHANGE_STATUS),
                .sw_detect_i(wr && sel && idx == PCS_IDX_CARD_DETECT_CTRL
                    && pwdata_i[PCS_CD_SW_INT]),
                .wdata_i(pwdata_i[7:0]),
                .status_o(status_w[g]),
                .power_o(power_w[g]),
                .change_o(change_w[g]),
                .switch_o(switch_w[g]),
                .oe_o(oe_w[g]),
                .any_change_o(pend_w[g])
            );
            always_ff @(posedge sys_clk_i) begin
                if (sys_rst_i) begin
                    supply_high_select_o[g] <= 1'b0;
                    supply_low_select_o[g] <= 1'b0;
                    prog_voltage_high_enable_o[g] <= 1'b0;
                    prog_voltage_low_enable_o[g] <= 1'b0;
                    socket_out_en_o[g] <= 1'b0;
                    buffer_enable_n_o[g] <= 1'b1;
                    change_pending_o[g] <= 1'b0;
                end else begin
                    supply_high_select_o[g] <= switch_w[g][3]; // RULE_11
                    supply_low_select_o[g] <= switch_w[g][2];
                    prog_voltage_high_enable_o[g] <= switch_w[g][1]; // RULE_12
                    prog_voltage_low_enable_o[g] <= switch_w[g][0];
                    socket_out_en_o[g] <= oe_w[g]; // RULE_08
                    buffer_enable_n_o[g] <= !oe_w[g];
                    change_pending_o[g] <= pend_w[g]; // RULE_16
                end
            end
        end
    endgenerate

    a_ready_one_wait: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        psel_i && !penable_i && state_ff != PCS_APB_WAIT ##1 psel_i && penable_i
        |=> pready_o) else $error("pready late");
    a_power_clear: assert property (@(posedge sys_clk_i) // RULE_07
        sys_rst_i |=> power_w[0] == 8'h00) else $error("power not cleared");
    a_change_clear: assert property (@(posedge sys_clk_i) // RULE_18
        sys_rst_i |=> change_w[0] == 8'h00) else $error("change not cleared");
    a_change_masked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_13
        (change_w[0][3:0] & ~change_en_ff[0][3:0]) == 4'h0) else $error("masked bit set");
    // A fresh event in the read cycle wins, so only quiet cycles must clear
    a_read_clears: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_15
        rd && sock == 2'h0 && idx == PCS_IDX_CHANGE_STATUS && !global_ff[PCS_GC_ACK_MODE]
        && g_sock[0].u_sock.set_ev == 4'h0 |=> change_w[0] == 8'h00)
        else $error("read did not clear");
    a_buffer_oe: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_08
        buffer_enable_n_o == ~socket_out_en_o) else $error("buffer enable mismatch");
    a_vcc_exclusive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_11
        (supply_high_select_o & supply_low_select_o) == '0) else $error("both supplies");
    a_vpp_exclusive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_12
        (prog_voltage_high_enable_o & prog_voltage_low_enable_o) == '0
        && (prog_voltage_low_enable_o & ~(supply_high_select_o | supply_low_select_o)) == '0)
        else $error("bad vpp enables");
    a_power_status: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE_01
        $past(status_w[0][PCS_ST_POWER]) == (switch_w[0][3] | switch_w[0][2]))
        else $error("power status wrong");
    c_write_power: cover property (@(posedge sys_clk_i) wr && idx == PCS_IDX_POWER_CTRL);
    c_change_set: cover property (@(posedge sys_clk_i) $rose(change_pending_o[0]));
    c_explicit_ack: cover property (@(posedge sys_clk_i)
        wr && idx == PCS_IDX_CHANGE_STATUS && global_ff[PCS_GC_ACK_MODE]);
endmodule // pcs_bank

// ---- tb/pcs_card_model.sv ----
// Card socket and external power latch model, all sockets.
// Assumes the bench requests pin levels; flags latch misuse on bad_o.
module pcs_card_model #(
    parameter int SOCKETS = 4
)(
    input wire logic sys_clk_i,
    input wire logic [SOCKETS*7-1:0] pins_req_i,
    input wire logic [SOCKETS*2-1:0] vs_req_i,
    input wire logic [SOCKETS-1:0] supply_high_select_i,
    input wire logic [SOCKETS-1:0] supply_low_select_i,
    input wire logic [SOCKETS-1:0] socket_out_en_i,
    output logic [SOCKETS*7-1:0] card_pins_o,
    output logic [SOCKETS*2-1:0] voltage_sense_o,
    output logic bad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_ff = 1'b0;
    initial begin
        card_pins_o = '0;
        voltage_sense_o = '0;
        bad_o = 1'b0;
    end
    always @(posedge sys_clk_i) begin
        toggle_ff <= ~toggle_ff;
        voltage_sense_o <= vs_req_i;
        for (int g = 0; g < SOCKETS; g++) begin
            // Spare pin wanders so any leak into status shows up in the status reads
            card_pins_o[g*7 +: 7] <= {toggle_ff, pins_req_i[g*7 +: 6]};
            if (supply_high_select_i[g] && supply_low_select_i[g]) begin
                bad_o <= 1'b1;
            end
            if (socket_out_en_i[g] && !(supply_high_select_i[g] || supply_low_select_i[g])) begin
                bad_o <= 1'b1;
            end
        end
    end
endmodule // pcs_card_model

// ---- tb/pcs_bank_tb.sv ----
// Self-checking bench for the four-socket status and power bank.
// Assumes the card model compiles first; APB master and checks live here.
module pcs_bank_tb
    import pcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} pcs_note_t;
    logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rnd = 32'd92948;
    logic [3:0] pstrb = 4'hf, vhi, vlo, phi, plo, oe, buf_n, pend;
    logic [27:0] pins_q = '0, card_pins;
    logic [7:0] vs_q = '0, vsense;
    logic pready, pslverr, bad, pend_q = 1'b0;
    pcs_note_t notes[$], nt;
    int num_errors = 0, comparisons = 0, rises = 0;
    always #5 sys_clk_i = ~sys_clk_i;
    pcs_bank i_pcs_bank (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .card_pins_i(card_pins), .voltage_sense_i(vsense), .supply_high_select_o(vhi),
        .supply_low_select_o(vlo), .prog_voltage_high_enable_o(phi),
        .prog_voltage_low_enable_o(plo), .socket_out_en_o(oe), .buffer_enable_n_o(buf_n),
        .change_pending_o(pend));
    pcs_card_model i_pcs_card_model (.sys_clk_i(sys_clk_i), .pins_req_i(pins_q),
        .vs_req_i(vs_q), .supply_high_select_i(vhi), .supply_low_select_i(vlo),
        .socket_out_en_i(oe), .card_pins_o(card_pins), .voltage_sense_o(vsense), .bad_o(bad));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [9:0] ad(input int s, input logic [7:0] i);
        return {s[1:0], i[5:0], 2'b00};
    endfunction
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp1(input string n, input logic e, input logic g);
        cmp(n, {31'h0, e}, {31'h0, g});
    endtask
    task test_done;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Watcher takes the oldest note for every answered transfer
    always @(posedge sys_clk_i) begin
        pend_q <= pend[0];
        if (pend[0] === 1'b1 && pend_q === 1'b0) rises++;
        if (psel && penable && pready === 1'b1) begin
            nt = notes.pop_front();
            cmp("prdata", nt.d & nt.m, prdata & nt.m);
            cmp("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
        end
    end
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [31:0] ed, input logic [31:0] em, input logic ee,
                       input logic [3:0] st = 4'hf);
        int n;
        notes.push_back('{ed, em, ee});
        @(posedge sys_clk_i);
        rnd = lfsr(rnd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {rnd[31:8], d};
        pstrb <= st;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) cmp1("pready", 1'b1, 1'b0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int s, input logic [7:0] i, input logic [7:0] d);
        apb(1'b1, ad(s, i), d, 32'h0, 32'h0, 1'b0);
    endtask
    task automatic rd(input int s, input logic [7:0] i, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
        apb(1'b0, ad(s, i), 8'h00, {24'h0, e}, {24'hffffff, m}, 1'b0);
    endtask
    // Pins cross two sync flops; five cycles covers flags too
    task automatic pin(input int s, input logic [5:0] v);
        @(posedge sys_clk_i);
        pins_q[s*7 +: 7] <= {1'b0, v};
        repeat (5) @(posedge sys_clk_i);
    endtask
    logic [7:0] tbl [5][2] = '{'{8'h2b, 8'h08}, '{8'h0b, 8'h00}, '{8'h2b, 8'h04},
                               '{8'h29, 8'h02}, '{8'h28, 8'h01}};
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        cmp1("watchdog", 1'b1, 1'b0);
        test_done;
    end
    initial begin
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        cmp("buffer_enable_n", 32'hf, {28'h0, buf_n});
        for (int s = 0; s < 4; s++) begin
            rd(s, PCS_IDX_POWER_CTRL, 8'h00);
            rd(s, PCS_IDX_CHANGE_STATUS, 8'h00);
            rnd = lfsr(rnd);
            pin(s, rnd[5:0]);
        end
        for (int s = 0; s < 4; s++) rd(s, PCS_IDX_PIN_STATUS, {2'b00, pins_q[s*7 +: 6]});
        apb(1'b0, 10'h00c, 8'h00, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b0, ad(0, PCS_IDX_PIN_STATUS) | 10'h001, 8'h00, 32'h0, 32'hffffffff, 1'b1);
        apb(1'b1, ad(2, PCS_IDX_POWER_CTRL), 8'h10, 32'h0, 32'h0, 1'b0, 4'h0);
        rd(2, PCS_IDX_POWER_CTRL, 8'h00);
        wr(3, PCS_IDX_PIN_STATUS, 8'hff);
        rd(3, PCS_IDX_PIN_STATUS, {2'b00, pins_q[26:21]});
        for (int c = 0; c < 16; c++) begin
            wr(1, PCS_IDX_POWER_CTRL, {2'b01, 1'b0, c[3:2], 1'b1, c[1:0]});
            repeat (2) @(posedge sys_clk_i);
            cmp1("supply_high", c[3:2] == 2'b10, vhi[1]);
            cmp1("supply_low", c[3:2] == 2'b11, vlo[1]);
            cmp1("prog_high", c[3] && c[1:0] == 2'b10, phi[1]);
            cmp1("prog_low", c[3] && c[1:0] == 2'b01, plo[1]);
            cmp1("other sockets", 1'b0, |{vhi[3:2], vhi[0], phi[3:2], phi[0]});
            rd(1, PCS_IDX_PIN_STATUS, {1'b0, c[3], pins_q[12:7]});
            rd(1, PCS_IDX_POWER_CTRL, {3'b000, c[3:2], 1'b0, c[1:0]});
        end
        // Supply already at 3.3V before the enable goes on
        wr(1, PCS_IDX_POWER_CTRL, 8'h98);
        repeat (2) @(posedge sys_clk_i);
        cmp1("out_en", 1'b1, oe[1]);
        cmp1("buffer_enable_n", 1'b0, buf_n[1]);
        wr(1, PCS_IDX_POWER_CTRL, 8'h18);
        repeat (2) @(posedge sys_clk_i);
        cmp1("out_en", 1'b0, oe[1]);
        cmp1("buffer_enable_n", 1'b1, buf_n[1]);
        wr(1, PCS_IDX_POWER_CTRL, 8'h00);
        pin(2, 6'h0c);
        vs_q[5:4] <= 2'b01;
        wr(2, PCS_IDX_POWER_CTRL, 8'h20);
        repeat (5) @(posedge sys_clk_i);
        cmp("auto 5V", 32'h2, {30'h0, vhi[2], vlo[2]});
        rd(2, PCS_IDX_CARD_DETECT_CTRL, 8'h40);
        vs_q[4] <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
        cmp("auto 3V", 32'h1, {30'h0, vhi[2], vlo[2]});
        pin(2, 6'h04);
        // Auto path adds the sync flops and two output stages
        repeat (2) @(posedge sys_clk_i);
        cmp("auto off", 32'h0, {30'h0, vhi[2], vlo[2]});
        wr(2, PCS_IDX_POWER_CTRL, 8'h00);
        pin(0, 6'h00);
        pin(0, 6'h2f);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h00);
        wr(0, PCS_IDX_CHANGE_ENABLE, 8'h0f);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h00, 8'h00);
        rises = 0;
        pin(0, 6'h2b);
        pin(0, 6'h2f);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h08);
        cmp("pending rises", 32'h1, rises);
        for (int k = 0; k < 5; k++) begin
            pin(0, tbl[k][0][5:0]);
            rd(0, PCS_IDX_CHANGE_STATUS, tbl[k][1]);
        end
        repeat (2) @(posedge sys_clk_i);
        cmp1("pending", 1'b0, pend[0]);
        wr(0, PCS_IDX_GLOBAL_CTRL, 8'h04);
        wr(0, PCS_IDX_CARD_DETECT_CTRL, 8'h20);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h08);
        wr(0, PCS_IDX_CHANGE_STATUS, 8'h04);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h08);
        cmp1("pending", 1'b1, pend[0]);
        wr(0, PCS_IDX_CHANGE_STATUS, 8'h08);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h00);
        repeat (2) @(posedge sys_clk_i);
        cmp1("pending", 1'b0, pend[0]);
        wr(0, PCS_IDX_GLOBAL_CTRL, 8'h00);
        wr(0, PCS_IDX_CARD_TYPE, 8'h01);
        pin(0, 6'h09);
        pin(0, 6'h29);
        rd(0, PCS_IDX_PIN_STATUS, 8'h29);
        pin(0, 6'h28);
        rd(0, PCS_IDX_CHANGE_STATUS, 8'h01);
        cmp1("latch fault", 1'b0, bad);
        test_done;
    end
endmodule // pcs_bank_tb
